// *** common/edhd_pkg.sv ***
// Constants and types for the enhanced/high-definition mode control block
package edhd_pkg;
   // Register offsets
   localparam logic [7:0] OFS_MASTER_SYNC = 8'h02;
   localparam logic [7:0] OFS_SYNC_TIMING = 8'h34;
   localparam logic [7:0] OFS_OUT_PROC = 8'h35;
   // Reset values
   localparam logic [7:0] RST_MASTER_SYNC = 8'h00;
   localparam logic [7:0] RST_SYNC_TIMING = 8'h48;
   localparam logic [7:0] RST_OUT_PROC = 8'h00;
   // Master sync register field
   localparam int B_MASTER_SYNC_EN = 7;
   // Sync timing control fields
   localparam int B_TIMING_RESET = 0;
   localparam int B_HSYNC_OUT = 1;
   localparam int B_VSYNC_OUT = 2;
   localparam int B_BLANK_LOW = 3;
   localparam int B_RESERVED = 5;
   localparam int B_VSYNC_SEL = 6;
   localparam int B_FREE_RUN = 7;
   // Output processing control fields
   localparam int B_RGB_IN = 1;
   localparam int B_SYNC_PBPR = 2;
   localparam int B_DAC_SWAP = 3;
   localparam int B_GAMMA_B = 4;
   localparam int B_GAMMA_EN = 5;
   localparam int B_AFILT_B = 6;
   localparam int B_AFILT_EN = 7;
   // Raster of the selected standard and sync pulse widths
   localparam int CNT_W = 12;
   localparam logic [11:0] H_TOTAL = 12'h35a;
   localparam logic [11:0] V_TOTAL = 12'h20d;
   localparam logic [11:0] H_SYNC_LEN = 12'h03e;
   localparam logic [11:0] V_SYNC_LEN = 12'h006;
   localparam int PIX_W = 10;
   // Pin positions in the pin vector
   localparam int P_HSYNC_N = 0;
   localparam int P_VSYNC_FIELD = 1;
   localparam int P_BLANK = 2;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // State of the top module, apart from the reset flops and the raster counters
   typedef struct packed {
      logic [2:0] pin_s1;
      logic [2:0] pin_s2;
      logic [2:0] pin_s3;
      logic [2:0] pin_f;
      logic [2:0] pin_d;
      logic [7:0] master;
      logic [7:0] timing;
      logic [7:0] outproc;
      logic [7:0] rdata;
      logic hsync_n;
      logic vsync_n;
      logic blank;
      logic [PIX_W-1:0] dac2;
      logic [PIX_W-1:0] dac3;
   } state_t;
endpackage

// *** design/edhd_raster_counter.sv ***
// One raster counter: wraps by the standard or by an external sync event
`timescale 1ns/100ps
module edhd_raster_counter #(
   parameter logic [11:0] TOTAL = 12'h001
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Control
   input wire logic i_hold,
   input wire logic i_step,
   input wire logic i_free,
   input wire logic i_ext_wrap,
   // Count
   output logic [edhd_pkg::CNT_W-1:0] o_count,
   output logic o_wrap
);
   logic [edhd_pkg::CNT_W-1:0] cnt_reg;
   logic [edhd_pkg::CNT_W-1:0] cnt_next;

   // Free mode wraps only on the external event, else at end of raster
   always_comb begin
      o_wrap = i_free ? i_ext_wrap : (i_step && cnt_reg == TOTAL - 12'h001);
      if (i_hold)
         cnt_next = '0;
      else if (o_wrap)
         cnt_next = '0;
      else if (i_step)
         cnt_next = cnt_reg + 12'h001;
      else
         cnt_next = cnt_reg;
   end

   // Count register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end

   assign o_count = cnt_reg;
endmodule

// *** design/edhd_mode_control_regs.sv ***
// Mode control registers and timing path of the ED/HD video block
//
// Overview of operation
// - Timing bit 0 at 1 holds the raster counters at zero, at 0 they run.
// - Sync output bits 1 and 2 act only while master sync bit 7 is set.
// - Timing bit 7 at 0 wraps counters by the standard, at 1 by sync.
// - Output bit 1 enables RGB input, and the register resets to zero.
// - Output bit 3 at 0 sends Pb to DAC 2 and Pr to DAC 3, at 1 swaps.
// - Output bit 5 turns gamma on, bit 4 picks curve A (0) or B (1).
// - Output bit 6 selects adaptive filter mode A (0) or B (1).
// - Output bit 7 enables the adaptive filter, at 0 it is bypassed.
// - Timing bit 6 picks a field input (0) or vertical sync input (1).
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module edhd_mode_control_regs (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Sync and blank pins
   input wire logic i_hsync_n,
   input wire logic i_vsync_field,
   input wire logic i_blank,
   // Pixel colour difference data
   input wire logic [edhd_pkg::PIX_W-1:0] i_pb,
   input wire logic [edhd_pkg::PIX_W-1:0] i_pr,
   // DAC data
   output logic [edhd_pkg::PIX_W-1:0] o_dac2,
   output logic [edhd_pkg::PIX_W-1:0] o_dac3,
   // Timing outputs
   output logic o_hsync_n,
   output logic o_vsync_n,
   output logic o_blank,
   output logic [edhd_pkg::CNT_W-1:0] o_h_count,
   output logic [edhd_pkg::CNT_W-1:0] o_v_count,
   // Processing controls
   output logic o_rgb_in_en,
   output logic o_sync_on_pbpr,
   output logic o_gamma_en,
   output logic o_gamma_curve_b,
   output logic o_afilt_en,
   output logic o_afilt_mode_b
);
   logic [1:0] rst_sync;
   logic rst_n;
   edhd_pkg::reg_req_t req;
   edhd_pkg::state_t s_reg;
   edhd_pkg::state_t s_next;
   logic h_ev;
   logic v_ev;
   logic h_wrap;
   logic hold;
   logic free;
   logic [edhd_pkg::CNT_W-1:0] h_cnt;
   logic [edhd_pkg::CNT_W-1:0] v_cnt;

   // Reset released through two flops
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // External sync events from filtered pins
   always_comb begin
      h_ev = s_reg.pin_d[edhd_pkg::P_HSYNC_N]
         & ~s_reg.pin_f[edhd_pkg::P_HSYNC_N];
      if (s_reg.timing[edhd_pkg::B_VSYNC_SEL])
         v_ev = s_reg.pin_d[edhd_pkg::P_VSYNC_FIELD]
            & ~s_reg.pin_f[edhd_pkg::P_VSYNC_FIELD];
      else
         v_ev = s_reg.pin_d[edhd_pkg::P_VSYNC_FIELD]
            ^ s_reg.pin_f[edhd_pkg::P_VSYNC_FIELD];
   end

   assign hold = s_reg.timing[edhd_pkg::B_TIMING_RESET];
   assign free = s_reg.timing[edhd_pkg::B_FREE_RUN];

   edhd_raster_counter #(.TOTAL(edhd_pkg::H_TOTAL)) u_h_counter (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_hold(hold),
      .i_step(1'b1),
      .i_free(free),
      .i_ext_wrap(h_ev),
      .o_count(h_cnt),
      .o_wrap(h_wrap)
   );

   edhd_raster_counter #(.TOTAL(edhd_pkg::V_TOTAL)) u_v_counter (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_hold(hold),
      .i_step(h_wrap),
      .i_free(free),
      .i_ext_wrap(v_ev),
      .o_count(v_cnt),
      .o_wrap()
   );

   // Next state: pin filter, register port, sync, blank and DAC routing
   always_comb begin
      s_next = s_reg;
      // Pin change counts only once second and third stage agree
      s_next.pin_s1 = {i_blank, i_vsync_field, i_hsync_n};
      s_next.pin_s2 = s_reg.pin_s1;
      s_next.pin_s3 = s_reg.pin_s2;
      if (s_reg.pin_s2 == s_reg.pin_s3)
         s_next.pin_f = s_reg.pin_s3;
      s_next.pin_d = s_reg.pin_f;
      // Register writes; bits not held read back as zero
      if (req.wr) begin
         case (req.addr)
            edhd_pkg::OFS_MASTER_SYNC: begin
               s_next.master = 8'h00;
               s_next.master[edhd_pkg::B_MASTER_SYNC_EN] =
                  req.wdata[edhd_pkg::B_MASTER_SYNC_EN];
            end
            // reserved bit kept as written, expected 0
            edhd_pkg::OFS_SYNC_TIMING: s_next.timing = req.wdata;
            edhd_pkg::OFS_OUT_PROC: s_next.outproc = req.wdata;
            default: ;
         endcase
      end
      // Read data valid in the cycle after the strobe only
      s_next.rdata = 8'h00;
      if (req.rd) begin
         case (req.addr)
            edhd_pkg::OFS_MASTER_SYNC: s_next.rdata = s_reg.master;
            edhd_pkg::OFS_SYNC_TIMING: s_next.rdata = s_reg.timing;
            edhd_pkg::OFS_OUT_PROC: s_next.rdata = s_reg.outproc;
            default: s_next.rdata = 8'h00;
         endcase
      end
      // sync outputs gated by master sync
      s_next.hsync_n = !(s_reg.master[edhd_pkg::B_MASTER_SYNC_EN]
         && s_reg.timing[edhd_pkg::B_HSYNC_OUT]
         && h_cnt < edhd_pkg::H_SYNC_LEN);
      s_next.vsync_n = !(s_reg.master[edhd_pkg::B_MASTER_SYNC_EN]
         && s_reg.timing[edhd_pkg::B_VSYNC_OUT]
         && v_cnt < edhd_pkg::V_SYNC_LEN);
      s_next.blank = s_reg.pin_f[edhd_pkg::P_BLANK]
         ^ s_reg.timing[edhd_pkg::B_BLANK_LOW];
      if (s_reg.outproc[edhd_pkg::B_DAC_SWAP]) begin
         s_next.dac2 = i_pr;
         s_next.dac3 = i_pb;
      end else begin
         s_next.dac2 = i_pb;
         s_next.dac3 = i_pr;
      end
   end

   // State register; sync pins idle high so no false edge at start
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.pin_s1 <= 3'h3;
         s_reg.pin_s2 <= 3'h3;
         s_reg.pin_s3 <= 3'h3;
         s_reg.pin_f <= 3'h3;
         s_reg.pin_d <= 3'h3;
         s_reg.master <= edhd_pkg::RST_MASTER_SYNC;
         s_reg.timing <= edhd_pkg::RST_SYNC_TIMING;
         s_reg.outproc <= edhd_pkg::RST_OUT_PROC;
         s_reg.hsync_n <= 1'b1;
         s_reg.vsync_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from registers
   assign o_rdata = s_reg.rdata;
   assign o_hsync_n = s_reg.hsync_n;
   assign o_vsync_n = s_reg.vsync_n;
   assign o_blank = s_reg.blank;
   assign o_dac2 = s_reg.dac2;
   assign o_dac3 = s_reg.dac3;
   assign o_h_count = h_cnt;
   assign o_v_count = v_cnt;
   assign o_rgb_in_en = s_reg.outproc[edhd_pkg::B_RGB_IN];
   assign o_sync_on_pbpr = s_reg.outproc[edhd_pkg::B_SYNC_PBPR];
   assign o_gamma_en = s_reg.outproc[edhd_pkg::B_GAMMA_EN];
   assign o_gamma_curve_b = s_reg.outproc[edhd_pkg::B_GAMMA_B];
   assign o_afilt_mode_b = s_reg.outproc[edhd_pkg::B_AFILT_B];
   assign o_afilt_en = s_reg.outproc[edhd_pkg::B_AFILT_EN];

   // Checks on the block's own behaviour
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!rst_n);

   a_timing_hold_zero: assert property (
      hold |=> (h_cnt == '0 && v_cnt == '0))
      else $error("counters not held by timing reset");
   a_hsync_master_gate: assert property (
      !s_reg.master[edhd_pkg::B_MASTER_SYNC_EN] |=> o_hsync_n)
      else $error("hsync driven without master sync");
   a_vsync_enable_gate: assert property (
      (s_reg.master[edhd_pkg::B_MASTER_SYNC_EN]
       && s_reg.timing[edhd_pkg::B_VSYNC_OUT] && v_cnt == '0)
      |=> !o_vsync_n)
      else $error("vsync missing while enabled");
   a_auto_line_wrap: assert property (
      (!hold && !free && h_cnt == edhd_pkg::H_TOTAL - 12'h001)
      |=> h_cnt == '0)
      else $error("line did not wrap at standard length");
   a_free_run_pass: assert property (
      (!hold && free && !h_ev && h_cnt == edhd_pkg::H_TOTAL - 12'h001)
      |=> h_cnt == edhd_pkg::H_TOTAL)
      else $error("free running counter wrapped without sync");
   a_rgb_write_take: assert property (
      (req.wr && req.addr == edhd_pkg::OFS_OUT_PROC)
      |=> o_rgb_in_en == $past(i_wdata[edhd_pkg::B_RGB_IN]))
      else $error("rgb enable did not follow write");
   a_dac_swap_route: assert property (
      s_reg.outproc[edhd_pkg::B_DAC_SWAP] && !req.wr
      |=> (o_dac2 == $past(i_pr) && o_dac3 == $past(i_pb)))
      else $error("dac swap routing wrong");
   a_gamma_write_take: assert property (
      (req.wr && req.addr == edhd_pkg::OFS_OUT_PROC)
      |=> (o_gamma_en == $past(i_wdata[edhd_pkg::B_GAMMA_EN])
           && o_gamma_curve_b == $past(i_wdata[edhd_pkg::B_GAMMA_B])))
      else $error("gamma controls did not follow write");
   a_afilt_mode_take: assert property (
      (req.wr && req.addr == edhd_pkg::OFS_OUT_PROC)
      |=> o_afilt_mode_b == $past(i_wdata[edhd_pkg::B_AFILT_B]))
      else $error("filter mode did not follow write");
   a_afilt_enable_take: assert property (
      (req.wr && req.addr == edhd_pkg::OFS_OUT_PROC)
      |=> o_afilt_en == $past(i_wdata[edhd_pkg::B_AFILT_EN]))
      else $error("filter enable did not follow write");
   a_field_edge_wrap: assert property (
      (!hold && free && !s_reg.timing[edhd_pkg::B_VSYNC_SEL]
       && (s_reg.pin_d[edhd_pkg::P_VSYNC_FIELD]
           != s_reg.pin_f[edhd_pkg::P_VSYNC_FIELD]))
      |=> v_cnt == '0)
      else $error("field toggle did not restart frame");
   a_blank_low_pol: assert property (
      (s_reg.timing[edhd_pkg::B_BLANK_LOW]
       && !s_reg.pin_f[edhd_pkg::P_BLANK]) |=> o_blank)
      else $error("active low blank not seen");
   a_read_timing_data: assert property (
      (req.rd && req.addr == edhd_pkg::OFS_SYNC_TIMING)
      |=> o_rdata == $past(s_reg.timing))
      else $error("timing register read wrong");

   c_swap_used: cover property (s_reg.outproc[edhd_pkg::B_DAC_SWAP]);
   c_line_wrap: cover property (h_wrap && !free);
   c_hsync_out: cover property (!o_hsync_n);
   c_free_vwrap: cover property (free && v_ev);
endmodule

// *** testbench/edhd_mode_control_regs_tb.sv ***
// Self-checking bench for the ED/HD mode control registers
`timescale 1ns/100ps
module edhd_mode_control_regs_tb;
   logic i_clk_sys, i_rst_n, i_wr, i_rd;
   logic i_hsync_n, i_vsync_field, i_blank;
   logic [7:0] i_addr, i_wdata, o_rdata;
   logic [9:0] i_pb, i_pr, o_dac2, o_dac3;
   logic o_hsync_n, o_vsync_n, o_blank;
   logic [11:0] o_h_count, o_v_count;
   logic o_rgb_in_en, o_sync_on_pbpr, o_gamma_en, o_gamma_curve_b;
   logic o_afilt_en, o_afilt_mode_b;
   int n_errors = 0;
   int comparisons = 0;
   logic [15:0] seed = 16'h000f;
   logic [7:0] r;
   logic [19:0] dac_exp;

   edhd_mode_control_regs i_edhd_mode_control_regs (.i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_hsync_n(i_hsync_n),
      .i_vsync_field(i_vsync_field), .i_blank(i_blank), .i_pb(i_pb),
      .i_pr(i_pr), .o_dac2(o_dac2), .o_dac3(o_dac3), .o_hsync_n(o_hsync_n),
      .o_vsync_n(o_vsync_n), .o_blank(o_blank), .o_h_count(o_h_count),
      .o_v_count(o_v_count), .o_rgb_in_en(o_rgb_in_en),
      .o_sync_on_pbpr(o_sync_on_pbpr), .o_gamma_en(o_gamma_en),
      .o_gamma_curve_b(o_gamma_curve_b), .o_afilt_en(o_afilt_en),
      .o_afilt_mode_b(o_afilt_mode_b));

   // Clock at 125 MHz
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   // Galois LFSR, repeatable from a fixed start
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
   endfunction

   // Expected DAC pair {dac2, dac3} for the swap setting
   function automatic logic [19:0] exp_dac(input logic swap,
      input logic [9:0] pb, input logic [9:0] pr);
      return swap ? {pr, pb} : {pb, pr};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   // Read data is looked at in the single cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask

   // Timing writes always clear the reserved bit
   // reserved bit zero
   task automatic wt(input logic [7:0] d);
      wr(edhd_pkg::OFS_SYNC_TIMING, d & 8'hdf);
   endtask

   // External hsync pulse, long enough to pass the pin filter
   task automatic pulse();
      @(posedge i_clk_sys);
      i_hsync_n <= 1'b0;
      repeat (6) @(posedge i_clk_sys);
      i_hsync_n <= 1'b1;
      cyc(6);
   endtask

   task automatic test_done();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs some 2000 cycles
   initial begin
      #200000;
      n_errors++;
      test_done();
   end

   initial begin
      {i_wr, i_rd, i_addr, i_wdata, i_pb, i_pr, i_blank} = '0;
      {i_hsync_n, i_vsync_field} = 2'b11;
      i_rst_n = 1'b0;
      repeat (12) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      cyc(3);
      rd(edhd_pkg::OFS_OUT_PROC, 8'h00);
      rd(edhd_pkg::OFS_SYNC_TIMING, 8'h48);
      rd(edhd_pkg::OFS_MASTER_SYNC, 8'h00);
      // Unmapped place ignores writes and reads zero
      wr(8'h36, 8'h77);
      rd(8'h36, 8'h00);
      wr(edhd_pkg::OFS_MASTER_SYNC, 8'hff);
      rd(edhd_pkg::OFS_MASTER_SYNC, 8'h80);
      // Output processing controls, corners then random values
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         r = (k == 0) ? 8'h00 : (k == 1) ? 8'hfe : seed[7:0] & 8'hfe;
         wr(edhd_pkg::OFS_OUT_PROC, r);
         rd(edhd_pkg::OFS_OUT_PROC, r);
         chk(o_rgb_in_en, r[1]);
         chk({o_gamma_en, o_gamma_curve_b}, r[5:4]);
         chk(o_afilt_mode_b, r[6]);
         chk(o_afilt_en, r[7]);
         chk(o_sync_on_pbpr, r[2]);
         seed = lfsr(seed);
         @(posedge i_clk_sys);
         i_pb <= seed[9:0];
         i_pr <= ~seed[9:0];
         cyc(2);
         dac_exp = exp_dac(r[3], seed[9:0], ~seed[9:0]);
         chk({o_dac2, o_dac3}, dac_exp);
      end
      // Counters held, sync outputs idle without master bit
      wr(edhd_pkg::OFS_MASTER_SYNC, 8'h00);
      wt(8'h03);
      cyc(5);
      chk({o_h_count, o_v_count}, 24'h0);
      wt(8'h06);
      cyc(10);
      chk(o_h_count > 0 && o_h_count < 12, 1'b1);
      chk({o_hsync_n, o_vsync_n}, 2'b11);
      wr(edhd_pkg::OFS_MASTER_SYNC, 8'h80);
      wt(8'h03);
      wt(8'h06);
      cyc(10);
      chk({o_hsync_n, o_vsync_n}, 2'b00);
      cyc(80);
      // Line sync ends, frame sync still in its first lines
      chk({o_hsync_n, o_vsync_n}, 2'b10);
      // Auto mode ignores external hsync, then wraps at the line end
      pulse();
      chk(o_h_count > 14, 1'b1);
      for (int k = 0; k < 1000 && o_h_count !== 12'h359; k++) cyc(1);
      chk(o_h_count, 12'h359);
      cyc(1);
      chk({o_h_count, o_v_count}, 24'h1);
      // Free mode with no sync runs past the standard line end
      wt(8'h80);
      for (int k = 0; k < 1000 && o_h_count !== 12'h359; k++) cyc(1);
      chk(o_h_count, 12'h359);
      cyc(1);
      chk(o_h_count, 12'h35a);
      // Free mode: hsync restarts the line, field or vsync wraps frame
      for (int s = 0; s < 3; s++) begin
         wt(8'h80 | ((s != 0) ? 8'h40 : 8'h00));
         cyc(20);
         // Output control bits clear keep both syncs idle
         chk({o_hsync_n, o_vsync_n}, 2'b11);
         pulse();
         chk(o_h_count < 14, 1'b1);
         pulse();
         @(posedge i_clk_sys);
         i_vsync_field <= ~i_vsync_field;
         cyc(8);
         // Field input wraps on either edge, vsync only on a fall
         chk(o_v_count == 0, s == 0 || i_vsync_field == 0);
      end
      // Blank polarity for both pin levels
      for (int k = 0; k < 4; k++) begin
         wt(k[1] ? 8'h08 : 8'h00);
         @(posedge i_clk_sys);
         i_blank <= k[0];
         cyc(6);
         chk(o_blank, k[0] ^ k[1]);
      end
      test_done();
   end
endmodule
